// [rtl/ucc_pkg.sv]
// shared constants and strap decoders for the conditioner configuration block
package ucc_pkg;
  localparam int CORE_CLK_MHZ = 100;
  localparam int SHUTDOWN_MIN_US = 20;
  localparam int SHUTDOWN_MIN_CYC = SHUTDOWN_MIN_US * CORE_CLK_MHZ;
  localparam int SUPPLY_STABLE_US = 100;
  localparam int I2C_SAMPLE_NS = 1000;
  localparam int I2C_SAMPLE_CYC = (I2C_SAMPLE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int I2C_RATE_KHZ = 100;
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h2C;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] OFS_AC_GAIN = 8'h01;
  localparam logic [7:0] OFS_CFG_HOLD = 8'h03;
  localparam logic [7:0] OFS_DC_GAIN = 8'h0E;
  localparam int FIELD_W = 3;
  localparam int AC_LSB = 4;
  localparam int DC_LSB = 0;
  localparam int HOLD_BIT = 0;
  localparam logic HOLD_RESET = 1'b1;
  localparam logic [2:0] AC_LVL0 = 3'h0;
  localparam logic [2:0] AC_LVL1 = 3'h1;
  localparam logic [2:0] AC_LVL2 = 3'h3;
  localparam logic [2:0] AC_LVL3 = 3'h7;
  localparam logic [2:0] DC_40MV = 3'h3;
  localparam logic [2:0] DC_60MV = 3'h5;
  localparam logic [2:0] DC_80MV = 3'h7;
  localparam logic [1:0] DC_STRAP_LOW = 2'h0;
  localparam logic [1:0] DC_STRAP_MID = 2'h1;
  localparam logic [1:0] DC_STRAP_HIGH = 2'h2;

  // resolved resistor level to field code
  function automatic logic [2:0] ucc_ac_code(input logic [1:0] lvl);
    case (lvl)
      2'h0: return AC_LVL0;
      2'h1: return AC_LVL1;
      2'h2: return AC_LVL2;
      default: return AC_LVL3;
    endcase
  endfunction

  // tri-level strap to field code; the unused code falls back to mid
  function automatic logic [2:0] ucc_dc_code(input logic [1:0] strap);
    case (strap)
      DC_STRAP_LOW: return DC_40MV;
      DC_STRAP_HIGH: return DC_80MV;
      default: return DC_60MV;
    endcase
  endfunction
endpackage

// [rtl/ucc_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/10ps
module ucc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // ucc_sync2

// [rtl/ucc_shutdown_filter.sv]
// minimum-width filter on the active-low shutdown pin
`timescale 1ns/10ps
module ucc_shutdown_filter
  import ucc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic shutdown_q
);
  localparam int CW = $clog2(SHUTDOWN_MIN_CYC + 1);
  logic pin_n_s;
  logic [CW-1:0] low_cnt_q;

  ucc_sync2 #(.WIDTH(1)) u_sync (
    .clk(core_clk),
    .rst(rst),
    .d(pin_n),
    .q(pin_n_s)
  );

  // count low time; a glitch shorter than the minimum never shuts down
  always_ff @(posedge core_clk)
  begin
    if (rst || pin_n_s)
      low_cnt_q <= '0;
    else if (low_cnt_q != CW'(SHUTDOWN_MIN_CYC))
      low_cnt_q <= low_cnt_q + 1'b1;
  end

  // held off from reset until the pin is seen high; release is immediate
  always_ff @(posedge core_clk)
  begin
    if (rst)
      shutdown_q <= 1'b1;
    else if (pin_n_s)
      shutdown_q <= 1'b0;
    else if (low_cnt_q == CW'(SHUTDOWN_MIN_CYC - 1))
      shutdown_q <= 1'b1;
  end

  a_shut_min_width: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(shutdown_q) |-> ($past(low_cnt_q) == CW'(SHUTDOWN_MIN_CYC - 1)))
    else $error("shutdown taken before minimum low time");

  a_high_releases: assert property (
    @(posedge core_clk) disable iff (rst)
    pin_n_s |=> !shutdown_q)
    else $error("shutdown held while pin high");
endmodule // ucc_shutdown_filter

// [rtl/ucc_config_ctrl.sv]
// configuration, strap capture, mode control and i2c slave of the conditioner
`timescale 1ns/10ps
module ucc_config_ctrl
  import ucc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic shutdown_in_n,
  input wire logic [1:0] ac_gain_strap,
  input wire logic [1:0] dc_gain_strap,
  input wire logic ls_detect,
  input wire logic fs_detect,
  input wire logic hs_detect,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic connect_indication_out,
  output logic comp_enable,
  output logic [2:0] ac_gain_out,
  output logic [2:0] dc_gain_out,
  output logic boost_run,
  output logic i2c_mode
);
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_ACTIVE} ucc_state_type;
  typedef enum logic [3:0] {L_IDLE, L_ADDR, L_ACK_ADDR, L_PTR, L_ACK_PTR,
                            L_WDATA, L_ACK_W, L_RDATA, L_RACK} ucc_link_type;
  localparam int SW = $clog2(I2C_SAMPLE_CYC + 1);

  logic shutdown;
  logic c_scl_s, c_sda_s, c_ls_s, c_fs_s, c_hs_s, c_req_s;
  logic [1:0] c_ac_s, c_dc_s;
  ucc_state_type state_q;
  logic [SW-1:0] settle_cnt_q;
  logic capture, settle_done, active, req_new, c_wr;
  logic [2:0] ac_field_q, dc_field_q;
  logic hold_q, req_seen_q, ack_tgl_q;
  logic [7:0] rdata_q;
  logic link_rst_s, l_scl_s, l_sda_s, l_en_s, l_ack_s;
  logic l_scl_d_q, l_sda_d_q;
  logic l_start, l_stop, l_rise, l_fall, l_byte_end, l_addr_hit;
  logic l_rd_first, l_rd_next, l_wr_issue;
  ucc_link_type l_state_q;
  logic [3:0] l_cnt_q;
  logic [7:0] l_shift_q, l_ptr_q, l_req_addr_q, l_req_wdata_q;
  logic l_req_tgl_q, l_req_we_q;
  logic [2:0] wdata_dc;

  ucc_shutdown_filter u_filter (
    .core_clk(core_clk),
    .rst(rst),
    .pin_n(shutdown_in_n),
    .shutdown_q(shutdown)
  );

  // pins and the link request toggle enter the core domain here
  ucc_sync2 #(.WIDTH(10)) u_csync (
    .clk(core_clk),
    .rst(rst),
    .d({scl_in, sda_in, ls_detect, fs_detect, hs_detect, ac_gain_strap, dc_gain_strap, l_req_tgl_q}),
    .q({c_scl_s, c_sda_s, c_ls_s, c_fs_s, c_hs_s, c_ac_s, c_dc_s, c_req_s})
  );

  // read decode; reserved offsets and bits read zero
  function automatic logic [7:0] ucc_read(input logic [7:0] ofs, input logic [2:0] ac,
                                          input logic hold, input logic [2:0] dc);
    logic [7:0] r;
    r = 8'h00;
    case (ofs)
      OFS_AC_GAIN: r[AC_LSB +: FIELD_W] = ac;
      OFS_CFG_HOLD: r[HOLD_BIT] = hold;
      OFS_DC_GAIN: r[DC_LSB +: FIELD_W] = dc;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  assign capture = (state_q == ST_OFF) && !shutdown;
  assign settle_done = (state_q == ST_SETTLE) && (settle_cnt_q == SW'(I2C_SAMPLE_CYC - 1));
  assign active = (state_q == ST_ACTIVE) && !shutdown;
  assign req_new = c_req_s != req_seen_q;
  assign c_wr = req_new && l_req_we_q && active && i2c_mode;
  assign wdata_dc = l_req_wdata_q[DC_LSB +: FIELD_W];

  // power-up and shutdown both fall back to off; release walks through settle
  always_ff @(posedge core_clk)
  begin
    if (rst || shutdown)
    begin
      state_q <= ST_OFF;
      settle_cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_OFF: state_q <= ST_SETTLE;
        ST_SETTLE:
        begin
          if (settle_done)
            state_q <= ST_ACTIVE;
          else
            settle_cnt_q <= settle_cnt_q + 1'b1;
        end
        ST_ACTIVE: state_q <= ST_ACTIVE;
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // gain fields: straps load once per release, later strap moves are ignored
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ac_field_q <= AC_LVL0;
      dc_field_q <= DC_60MV;
    end
    else if (capture)
    begin
      ac_field_q <= ucc_ac_code(c_ac_s);
      dc_field_q <= ucc_dc_code(c_dc_s);
    end
    else if (c_wr && l_req_addr_q == OFS_AC_GAIN)
      ac_field_q <= l_req_wdata_q[AC_LSB +: FIELD_W];
    else if (c_wr && l_req_addr_q == OFS_DC_GAIN)
      dc_field_q <= wdata_dc;
  end

  // hold bit: set by shutdown, which outranks a write in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst || shutdown)
      hold_q <= HOLD_RESET;
    else if (settle_done && !(c_scl_s && c_sda_s))
      hold_q <= 1'b0;
    else if (c_wr && l_req_addr_q == OFS_CFG_HOLD)
      hold_q <= l_req_wdata_q[HOLD_BIT];
  end

  // i2c mode decided once, a short settle after release
  always_ff @(posedge core_clk)
  begin
    if (rst || shutdown)
      i2c_mode <= 1'b0;
    else if (settle_done)
      i2c_mode <= c_scl_s && c_sda_s;
  end

  // answer every link request so the slave never waits forever
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      req_seen_q <= c_req_s;
      if (req_new)
      begin
        ack_tgl_q <= c_req_s;
        rdata_q <= ucc_read(l_req_addr_q, ac_field_q, hold_q, dc_field_q);
      end
    end
  end

  // mode outputs; the data channel itself passes untouched in every mode
  always_ff @(posedge core_clk)
  begin
    if (rst || shutdown)
    begin
      connect_indication_out <= 1'b0;
      comp_enable <= 1'b0;
      boost_run <= 1'b0;
      ac_gain_out <= AC_LVL0;
      dc_gain_out <= DC_40MV;
    end
    else
    begin
      connect_indication_out <= active && (c_ls_s || c_fs_s || c_hs_s);
      comp_enable <= active && c_hs_s && !hold_q;
      boost_run <= active && !hold_q;
      ac_gain_out <= ac_field_q;
      dc_gain_out <= dc_field_q;
    end
  end

  // link domain: reset, pins, enable and ack enter through synchronisers
  ucc_sync2 #(.WIDTH(1)) u_lrst (
    .clk(link_clk),
    .rst(1'b0),
    .d(rst),
    .q(link_rst_s)
  );

  ucc_sync2 #(.WIDTH(4)) u_lsync (
    .clk(link_clk),
    .rst(link_rst_s),
    .d({scl_in, sda_in, i2c_mode, ack_tgl_q}),
    .q({l_scl_s, l_sda_s, l_en_s, l_ack_s})
  );

  // delayed copies for bus edge detection; the slave only ever pulls low
  always_ff @(posedge link_clk)
  begin
    sda_out <= 1'b0;
    if (link_rst_s)
    begin
      l_scl_d_q <= 1'b1;
      l_sda_d_q <= 1'b1;
    end
    else
    begin
      l_scl_d_q <= l_scl_s;
      l_sda_d_q <= l_sda_s;
    end
  end

  assign l_start = l_scl_s && l_scl_d_q && l_sda_d_q && !l_sda_s;
  assign l_stop = l_scl_s && l_scl_d_q && !l_sda_d_q && l_sda_s;
  assign l_rise = l_scl_s && !l_scl_d_q;
  assign l_fall = !l_scl_s && l_scl_d_q;
  assign l_byte_end = l_fall && (l_cnt_q == BYTE_BITS);
  assign l_addr_hit = l_shift_q[7:1] == I2C_SLAVE_ADDR;
  assign l_rd_first = (l_state_q == L_ADDR) && l_byte_end && l_addr_hit && l_shift_q[0];
  assign l_rd_next = (l_state_q == L_RDATA) && l_fall && (l_cnt_q == BYTE_BITS - 4'h1);
  assign l_wr_issue = (l_state_q == L_WDATA) && l_byte_end;

  // slave protocol: no clock stretching, read data prefetched a bit early
  always_ff @(posedge link_clk)
  begin
    if (link_rst_s || !l_en_s || l_stop)
    begin
      l_state_q <= L_IDLE;
      l_cnt_q <= '0;
      sda_oe <= 1'b0;
      if (link_rst_s)
        l_shift_q <= 8'h00;
    end
    else if (l_start)
    begin
      l_state_q <= L_ADDR;
      l_cnt_q <= '0;
      sda_oe <= 1'b0;
    end
    else if (l_rise)
    begin
      case (l_state_q)
        L_ADDR, L_PTR, L_WDATA:
        begin
          l_shift_q <= {l_shift_q[6:0], l_sda_s};
          l_cnt_q <= l_cnt_q + 4'h1;
        end
        L_RACK:
        begin
          if (l_sda_s)
            l_state_q <= L_IDLE;
        end
        default: l_cnt_q <= l_cnt_q;
      endcase
    end
    else if (l_fall)
    begin
      case (l_state_q)
        L_ADDR:
        begin
          if (l_byte_end)
          begin
            sda_oe <= l_addr_hit;
            l_state_q <= l_addr_hit ? L_ACK_ADDR : L_IDLE;
          end
        end
        L_ACK_ADDR:
        begin
          l_cnt_q <= '0;
          l_state_q <= l_shift_q[0] ? L_RDATA : L_PTR;
          sda_oe <= l_shift_q[0] && !rdata_q[7];
          l_shift_q <= rdata_q;
        end
        L_PTR, L_WDATA:
        begin
          if (l_byte_end)
          begin
            sda_oe <= 1'b1;
            l_state_q <= (l_state_q == L_PTR) ? L_ACK_PTR : L_ACK_W;
          end
        end
        L_ACK_PTR, L_ACK_W:
        begin
          sda_oe <= 1'b0;
          l_cnt_q <= '0;
          l_state_q <= L_WDATA;
        end
        L_RDATA:
        begin
          if (l_rd_next)
          begin
            sda_oe <= 1'b0;
            l_state_q <= L_RACK;
          end
          else
          begin
            l_cnt_q <= l_cnt_q + 4'h1;
            sda_oe <= !l_shift_q[6];
            l_shift_q <= {l_shift_q[6:0], 1'b0};
          end
        end
        L_RACK:
        begin
          l_cnt_q <= '0;
          l_state_q <= L_RDATA;
          sda_oe <= !rdata_q[7];
          l_shift_q <= rdata_q;
        end
        default: l_state_q <= L_IDLE;
      endcase
    end
  end

  // request words stay still from toggle until the next byte, so the core reads them safely
  always_ff @(posedge link_clk)
  begin
    if (link_rst_s)
    begin
      l_req_tgl_q <= 1'b0;
      l_req_we_q <= 1'b0;
      l_req_addr_q <= 8'h00;
      l_req_wdata_q <= 8'h00;
      l_ptr_q <= 8'h00;
    end
    else
    begin
      if (l_rd_first || l_rd_next || l_wr_issue)
        l_req_tgl_q <= ~l_req_tgl_q;
      if (l_rd_first || l_wr_issue)
      begin
        l_req_we_q <= l_wr_issue;
        l_req_addr_q <= l_ptr_q;
        l_req_wdata_q <= l_shift_q;
      end
      else if (l_rd_next)
      begin
        l_req_we_q <= 1'b0;
        l_req_addr_q <= l_ptr_q + 8'h01;
      end
      if ((l_state_q == L_PTR) && l_byte_end)
        l_ptr_q <= l_shift_q;
      else if (l_rd_next || ((l_state_q == L_ACK_W) && l_fall))
        l_ptr_q <= l_ptr_q + 8'h01;
    end
  end

  sequence s_release;
    (state_q == ST_OFF) && !shutdown ##1 (state_q == ST_SETTLE);
  endsequence

  sequence s_sampled;
    settle_done && !shutdown;
  endsequence

  a_ls_connect: assert property (
    @(posedge core_clk) disable iff (rst)
    (active && c_ls_s && !c_hs_s) |=> (connect_indication_out && !comp_enable))
    else $error("low speed attach handled wrongly");

  a_fs_connect: assert property (
    @(posedge core_clk) disable iff (rst)
    (active && c_fs_s && !c_hs_s) ##1 !shutdown |-> (connect_indication_out && !comp_enable))
    else $error("full speed attach handled wrongly");

  a_hs_comp: assert property (
    @(posedge core_clk) disable iff (rst)
    (active && c_hs_s && !hold_q) |=>
      (comp_enable && connect_indication_out && ac_gain_out == $past(ac_field_q)
       && dc_gain_out == $past(dc_field_q)))
    else $error("high speed compensation missing");

  a_shut_nocomp: assert property (
    @(posedge core_clk) disable iff (rst)
    shutdown |=> !comp_enable && !boost_run)
    else $error("compensation active in shutdown");

  a_shut_nocd: assert property (
    @(posedge core_clk) disable iff (rst)
    shutdown [*2] |-> !connect_indication_out)
    else $error("connect indication driven in shutdown");

  a_i2c_detect: assert property (
    @(posedge core_clk) disable iff (rst)
    s_sampled |=> (i2c_mode == $past(c_scl_s && c_sda_s)))
    else $error("i2c mode sampled wrongly");

  a_hold_auto: assert property (
    @(posedge core_clk) disable iff (rst || shutdown)
    s_sampled ##0 !(c_scl_s && c_sda_s) |=> !hold_q ##1 boost_run)
    else $error("hold not cleared without i2c mode");

  a_hold_reset: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(rst) |-> hold_q && !boost_run)
    else $error("hold not set after reset");

  a_strap_dc: assert property (
    @(posedge core_clk) disable iff (rst)
    s_release |-> (dc_field_q == ucc_dc_code($past(c_dc_s))))
    else $error("dc strap not captured");

  a_strap_ac: assert property (
    @(posedge core_clk) disable iff (rst)
    s_release |-> (ac_field_q == ucc_ac_code($past(c_ac_s))))
    else $error("ac strap not captured");

  a_dc_write: assert property (
    @(posedge core_clk) disable iff (rst || shutdown)
    (c_wr && l_req_addr_q == OFS_DC_GAIN) |=> (dc_field_q == $past(wdata_dc)))
    else $error("dc gain write lost");

  a_addr_ack: assert property (
    @(posedge link_clk) disable iff (link_rst_s || !l_en_s)
    ((l_state_q == L_ADDR) && l_byte_end && !l_start && !l_stop) |=> (sda_oe == $past(l_addr_hit)))
    else $error("address acknowledge mismatch");

  // read data is taken from the core unsynchronised, so the answer must be back first
  a_read_ready: assert property (
    @(posedge link_clk) disable iff (link_rst_s || !l_en_s)
    ((((l_state_q == L_ACK_ADDR) && l_shift_q[0]) || (l_state_q == L_RACK)) && l_fall)
      |-> (l_ack_s == l_req_tgl_q))
    else $error("read data loaded before core answered");
endmodule // ucc_config_ctrl

// [testbench/ucc_i2c_master.sv]
// behavioural i2c master on the configuration port, with the wired-and bus
`timescale 1ns/10ps
module ucc_i2c_master #(
  parameter int HALF_NS = 5000
) (
  input wire logic bus_up,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic scl_q;
  logic sda_low_q;
  // pull-ups only when the bus is fitted; otherwise both pins read low
  assign scl = bus_up & scl_q;
  assign sda = bus_up & ~sda_low_q & ~sda_oe;
  initial
  begin
    scl_q = 1'b1;
    sda_low_q = 1'b0;
  end
  // start (a=0,b=1) or stop (a=1,b=0): sda moves while scl is high
  task automatic edge_cond(input logic a, input logic b);
    #(HALF_NS / 2) sda_low_q = a;
    #(HALF_NS / 2) scl_q = 1'b1;
    #(HALF_NS / 2) sda_low_q = b;
    #(HALF_NS / 2) scl_q = ~b;
  endtask
  // data changes mid-low, well after the slave's release at the fall
  task automatic bit_slot(input logic b, output logic seen);
    #(HALF_NS / 2) sda_low_q = ~b;
    #(HALF_NS / 2) scl_q = 1'b1;
    #(HALF_NS / 2) seen = sda;
    #(HALF_NS / 2) scl_q = 1'b0;
  endtask
  // one byte msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(tx[i], s);
      rx[i] = s;
    end
    bit_slot(last, s);
    ack = ~s;
  endtask
endmodule // ucc_i2c_master

// [testbench/usb_conditioner_config_ctrl_tb.sv]
// self-checking bench for the conditioner configuration block
`timescale 1ns/10ps
module usb_conditioner_config_ctrl_tb;
  import ucc_pkg::*;
  logic core_clk, link_clk, rst, shutdown_in_n, ls_detect, fs_detect, hs_detect, bus_up;
  logic [1:0] ac_gain_strap, dc_gain_strap;
  logic scl_w, sda_w, sda_oe, sda_out_w, connect_indication_out, comp_enable, boost_run, i2c_mode;
  logic [2:0] ac_gain_out, dc_gain_out;
  logic [9:0] st;
  int n_mismatch, num_checks;
  localparam logic [2:0] AC_TAB [4] = '{AC_LVL0, AC_LVL1, AC_LVL2, AC_LVL3};
  localparam logic [2:0] DC_TAB [3] = '{DC_40MV, DC_60MV, DC_80MV};
  // one vector of all mode outputs keeps each check to one line
  assign st = {connect_indication_out, comp_enable, boost_run, i2c_mode, ac_gain_out, dc_gain_out};

  ucc_config_ctrl ucc_config_ctrl_inst (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
    .shutdown_in_n(shutdown_in_n), .ac_gain_strap(ac_gain_strap), .dc_gain_strap(dc_gain_strap),
    .ls_detect(ls_detect), .fs_detect(fs_detect), .hs_detect(hs_detect), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out_w), .sda_oe(sda_oe), .connect_indication_out(connect_indication_out), .comp_enable(comp_enable),
    .ac_gain_out(ac_gain_out), .dc_gain_out(dc_gain_out), .boost_run(boost_run), .i2c_mode(i2c_mode));
  // faster than the nominal bus rate to keep the run short
  ucc_i2c_master #(.HALF_NS(1500)) ucc_i2c_master_inst (.bus_up(bus_up), .sda_oe(sda_oe), .scl(scl_w),
    .sda(sda_w));

  // clocks: link clock free running, unrelated phase
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic release_pins(input logic [1:0] ac, input logic [1:0] dc, input logic up);
    ac_gain_strap = ac;
    dc_gain_strap = dc;
    bus_up = up;
    shutdown_in_n = 1'b1;
    cyc(150);
  endtask
  task automatic shut;
    shutdown_in_n = 1'b0;
    cyc(SHUTDOWN_MIN_CYC + 20);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, input logic exp_ack);
    logic [7:0] rx;
    logic a;
    ucc_i2c_master_inst.edge_cond(1'b0, 1'b1);
    ucc_i2c_master_inst.xfer({dev, 1'b0}, 1'b1, rx, a);
    chk({9'h0, a}, {9'h0, exp_ack}, "address ack");
    if (a === 1'b1)
    begin
      ucc_i2c_master_inst.xfer(ofs, 1'b1, rx, a);
      ucc_i2c_master_inst.xfer(d, 1'b1, rx, a);
    end
    ucc_i2c_master_inst.edge_cond(1'b1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] rx;
    logic a;
    ucc_i2c_master_inst.edge_cond(1'b0, 1'b1);
    ucc_i2c_master_inst.xfer({I2C_SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
    ucc_i2c_master_inst.xfer(ofs, 1'b1, rx, a);
    ucc_i2c_master_inst.edge_cond(1'b0, 1'b1);
    ucc_i2c_master_inst.xfer({I2C_SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
    ucc_i2c_master_inst.xfer(8'hFF, 1'b1, d, a);
    ucc_i2c_master_inst.edge_cond(1'b1, 1'b0);
  endtask

  // every strap level through a full shutdown and release, high-speed link attached
  task automatic t_strap_sweep;
    hs_detect = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      shut();
      chk(st, {4'h0, AC_LVL0, DC_40MV}, "shutdown outputs");
      release_pins(i[1:0], 2'(i % 3), 1'b0);
      chk(st, {4'hE, AC_TAB[i], DC_TAB[i % 3]}, "strap capture");
    end
  endtask
  // attach kinds in turn
  task automatic t_modes;
    hs_detect = 1'b0;
    ls_detect = 1'b1;
    cyc(10);
    chk(st, {4'hA, AC_LVL3, DC_40MV}, "low speed");
    ls_detect = 1'b0;
    fs_detect = 1'b1;
    cyc(10);
    chk(st, {4'hA, AC_LVL3, DC_40MV}, "full speed");
    fs_detect = 1'b0;
    hs_detect = 1'b1;
    cyc(10);
    chk(st, {4'hE, AC_LVL3, DC_40MV}, "high speed");
  endtask
  // straps move without a toggle, and a too-short low pulse
  task automatic t_filter_latch;
    ac_gain_strap = 2'h0;
    dc_gain_strap = 2'h2;
    shutdown_in_n = 1'b0;
    cyc(SHUTDOWN_MIN_CYC - 100);
    shutdown_in_n = 1'b1;
    cyc(20);
    chk(st, {4'hE, AC_LVL3, DC_40MV}, "short pulse kept settings");
    shut();
    chk(st, {4'h0, AC_LVL0, DC_40MV}, "long pulse shut down");
  endtask
  // bus fitted: hold stays set until cleared, gains reprogrammed
  task automatic t_i2c;
    logic [7:0] d;
    hs_detect = 1'b0;
    release_pins(2'h1, 2'h1, 1'b1);
    chk(st, {4'h1, AC_LVL1, DC_60MV}, "i2c mode, hold set");
    rd(OFS_CFG_HOLD, d);
    chk({2'h0, d}, 10'h001, "hold register");
    rd(OFS_AC_GAIN, d);
    chk({2'h0, d}, {3'h0, AC_LVL1, 4'h0}, "ac field readback");
    wr(I2C_SLAVE_ADDR, OFS_AC_GAIN, (d & 8'h8F) | {1'b0, AC_LVL3, 4'h0}, 1'b1);
    // reserved bits of the dc register read zero, so zero keeps them
    wr(I2C_SLAVE_ADDR, OFS_DC_GAIN, {5'h00, DC_80MV}, 1'b1);
    wr(I2C_SLAVE_ADDR, OFS_CFG_HOLD, 8'h00, 1'b1);
    cyc(1);
    hs_detect = 1'b1;
    cyc(10);
    chk(st, {4'hF, AC_LVL3, DC_80MV}, "boost after hold clear");
    wr(I2C_SLAVE_ADDR + 7'h01, OFS_CFG_HOLD, 8'h01, 1'b0);
    cyc(10);
    chk(st, {4'hF, AC_LVL3, DC_80MV}, "foreign address ignored");
    chk({9'h000, sda_out_w}, 10'h000, "sda data level");
  endtask

  // watchdog well beyond the expected run of some 760 us
  initial
  begin
    #1000000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    rst = 1'b1;
    shutdown_in_n = 1'b0;
    {ls_detect, fs_detect, hs_detect, bus_up} = 4'h0;
    ac_gain_strap = 2'h0;
    dc_gain_strap = 2'h0;
    // long enough to cover three link clock edges
    cyc(16);
    rst = 1'b0;
    cyc(SUPPLY_STABLE_US * CORE_CLK_MHZ);
    t_strap_sweep();
    t_modes();
    t_filter_latch();
    t_i2c();
    complete_run();
  end
endmodule // usb_conditioner_config_ctrl_tb
